/* File: rtl/eis_cfg.svh */
// eis_cfg.svh: offsets, field positions, reset values and widths
// assumes: included by bare name, before any module that uses it
`ifndef EIS_CFG_SVH
`define EIS_CFG_SVH
// source counts: flagged sources plus the flagless dropout source
`define EIS_NSRC 18
`define EIS_NFLAG 17
`define EIS_DROP_SRC 5'h11
// register byte offsets on the bus
`define EIS_OFF_IE 8'h00
`define EIS_OFF_EXTENDED_IRQ_ENABLE_REG_1 8'h04
`define EIS_OFF_EXTENDED_IRQ_ENABLE_REG_2 8'h08
`define EIS_OFF_PRIO1 8'h0c
`define EIS_OFF_PRIO2 8'h10
`define EIS_OFF_PEND 8'h14
`define EIS_OFF_REGCN 8'h18
`define EIS_OFF_STAT 8'h1c
// field positions
`define EIS_GEN_BIT 7
`define EIS_REG_EN_BIT 7
`define EIS_DROP_STAT_BIT 0
// reset values
`define EIS_IE_RST 8'h00
`define EIS_REG_EN_RST 1'b1
// bus answers
`define EIS_RESP_OKAY 2'b00
`define EIS_RESP_SLVERR 2'b10
`endif

/* File: rtl/eis_pkg.sv */
// eis_pkg: state types of the interrupt controller
// assumes: eis_cfg.svh gives the counts used here
`include "eis_cfg.svh"
package eis_pkg;
	// synchroniser chain
	typedef struct packed {
		logic s2;
		logic s1;
	} eis_sync_t;
	// whole controller state, registered in one place
	typedef struct packed {
		logic [7:0] ie;
		logic [7:0] extended_irq_enable_reg_1;
		logic [7:0] extended_irq_enable_reg_2;
		logic [16:0] prio1;
		logic prio2;
		logic [16:0] pend;
		logic reg_en;
		logic [1:0] active;
		logic req;
		logic req_lvl;
		logic [4:0] req_src;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} eis_state_t;
endpackage

/* File: rtl/eis_sync.sv */
// eis_sync: two-flop synchroniser for one asynchronous level
// assumes: input comes from a pin, output read on aclk only
`timescale 1ns/10ps
`default_nettype none
module eis_sync
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// level in and out
	input wire logic din,
	output logic dout
);
	// chain state
	eis_pkg::eis_sync_t st;
	eis_pkg::eis_sync_t next_st;

	// first flop is read only by the second
	always_comb
	begin
		next_st.s1 = din;
		next_st.s2 = st.s1;
	end

	// register the chain
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign dout = st.s2;
endmodule
`default_nettype wire

/* File: rtl/eis_arbiter.sv */
// eis_arbiter: picks the lowest-numbered source in each priority level
// assumes: eligible vector already gated by all enables
`timescale 1ns/10ps
`default_nettype none
`include "eis_cfg.svh"
module eis_arbiter
#(
	parameter int NSRC = `EIS_NSRC
)
(
	// eligible sources and their level
	input wire logic [NSRC-1:0] elig,
	input wire logic [NSRC-1:0] prio,
	// winners
	output logic hi_any,
	output logic [4:0] hi_idx,
	output logic lo_any,
	output logic [4:0] lo_idx
);
	if (NSRC < 1 || NSRC > 32)
	begin : g_bad_nsrc
		$error("eis_arbiter: NSRC must be 1 to 32");
	end

	// fixed order: lowest index wins
	function automatic logic [5:0] first_set(input logic [NSRC-1:0] v);
		logic [5:0] r;
		r = '0;
		for (int i = NSRC - 1; i >= 0; i--)
			if (v[i])
				r = {1'b1, 5'(i)};
		return r;
	endfunction

	// same search for both levels
	always_comb
	begin
		{hi_any, hi_idx} = first_set(elig & prio);
		{lo_any, lo_idx} = first_set(elig & ~prio);
	end
endmodule
`default_nettype wire

/* File: rtl/eis_irq_ctrl.sv */
// eis_irq_ctrl: extended interrupt controller with AXI4-Lite registers
// assumes: core pulses irq_ack when it calls the vector and return_from_interrupt_done
// when the return completes; events are aclk pulses; dropout is async
//
// How it works
// [R1] eighteen sources, two priority levels arbitrated
// [R2] events set pending flags regardless of enables
// [R3] enabled pending flag raises request for core call
// [R4] return instruction ends service, core resumes program
// [R5] disabled source never produces a request
// [R6] per-source enables act only under global enable
// [R7] global enable low blocks every source
// [R8] request latched one cycle survives enable clear
// [R9] software pads enable clears with two-byte opcode
// [R10] chosen flags clear on vector, others by software
// [R11] flag still set after return requests again
// [R12] software write of one acts as event
// [R13] dropout requests while low and enabled, flagless; here it requests while dropout_in is high
// [R14] dropout status readable, hardware clears it
// [R15] regulator enabled by reset, software may disable
// [R16] high preempts low; equal priority by index
`timescale 1ns/10ps
`default_nettype none
`include "eis_cfg.svh"
module eis_irq_ctrl
#(
	parameter int ADDR_W = 8,
	parameter logic [16:0] AUTO_CLR = 17'h00000
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// axi4-lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// axi4-lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// interrupt events from peripherals
	input wire logic [16:0] src_event,
	input wire logic dropout_in,
	// processor core side
	output logic irq_req,
	output logic [4:0] irq_vector,
	output logic irq_level,
	input wire logic irq_ack,
	input wire logic return_from_interrupt_done,
	// regulator control
	output logic regulator_enable
);
	if (ADDR_W < 8)
	begin : g_bad_addr
		$error("eis_irq_ctrl: ADDR_W must be at least 8");
	end
	////////////////////////////////////////////////////////////////////
	// state and helpers

	eis_pkg::eis_state_t st; // all registers
	eis_pkg::eis_state_t next_st; // next value
	logic drop_sync; // dropout level on aclk
	logic [17:0] en_vec; // individual enables by source
	logic [17:0] elig; // sources allowed to request
	logic [17:0] prio_vec; // level of each source
	logic hi_any; // a high source waits
	logic [4:0] hi_idx; // its index
	logic lo_any; // a low source waits
	logic [4:0] lo_idx; // its index
	logic wr_do; // write committed this cycle
	logic [31:0] rd_word; // read mux output
	logic rd_hit; // read address mapped

	// byte-lane merge for register writes
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (strb[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		return r;
	endfunction

	// enables gathered into one source-ordered vector
	function automatic logic [17:0] gather_en(input logic [7:0] ie,
		input logic [7:0] e1, input logic [7:0] e2);
		return {e2[0], e2[2:1], e1, ie[6:0]};
	endfunction

	////////////////////////////////////////////////////////////////////
	// submodules

	// dropout comparator output is asynchronous
	eis_sync u_drop_sync
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.din(dropout_in),
		.dout(drop_sync)
	);

	// fixed-order pick per level
	eis_arbiter #(.NSRC(`EIS_NSRC)) u_arb
	(
		.elig(elig),
		.prio(prio_vec),
		.hi_any(hi_any),
		.hi_idx(hi_idx),
		.lo_any(lo_any),
		.lo_idx(lo_idx)
	);

	////////////////////////////////////////////////////////////////////
	// source gating

	// individual enables only count under the global one
	always_comb
	begin
		en_vec = gather_en(st.ie, st.extended_irq_enable_reg_1, st.extended_irq_enable_reg_2); // [R6]
		// dropout has no flag: its live level is the source [R13]
		elig = {drop_sync, st.pend} & en_vec // [R5]
			& {18{st.ie[`EIS_GEN_BIT]}}; // [R7]
		prio_vec = {st.prio2, st.prio1}; // [R1]
	end

	////////////////////////////////////////////////////////////////////
	// register read mux

	// reserved bits read zero
	always_comb
	begin
		rd_word = '0;
		rd_hit = 1'b1;
		case (araddr[7:0])
			`EIS_OFF_IE: rd_word[7:0] = st.ie;
			`EIS_OFF_EXTENDED_IRQ_ENABLE_REG_1: rd_word[7:0] = st.extended_irq_enable_reg_1;
			`EIS_OFF_EXTENDED_IRQ_ENABLE_REG_2: rd_word[7:0] = st.extended_irq_enable_reg_2;
			`EIS_OFF_PRIO1: rd_word[16:0] = st.prio1;
			`EIS_OFF_PRIO2: rd_word[0] = st.prio2;
			`EIS_OFF_PEND: rd_word[16:0] = st.pend;
			`EIS_OFF_REGCN:
			begin
				rd_word[`EIS_REG_EN_BIT] = st.reg_en;
				// live status, cleared when dropout ends [R14]
				rd_word[`EIS_DROP_STAT_BIT] = drop_sync;
			end
			`EIS_OFF_STAT:
				rd_word[11:0] = {st.active, st.req, st.req_lvl,
					3'h0, st.req_src};
			default: rd_hit = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// next state

	// bus, register updates, flags and request in one pass
	always_comb
	begin
		next_st = st;
		wr_do = st.aw_got && st.w_got && !st.bvalid;

		// address and data may arrive in either order
		if (awvalid && awready)
		begin
			next_st.aw_got = 1'b1;
			next_st.aw_addr = awaddr[7:0];
		end
		if (wvalid && wready)
		begin
			next_st.w_got = 1'b1;
			next_st.w_data = wdata;
			next_st.w_strb = wstrb;
		end

		// commit once both halves are held
		if (wr_do)
		begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = `EIS_RESP_OKAY;
			case (st.aw_addr)
				`EIS_OFF_IE:
					next_st.ie = 8'(wmerge({24'h0, st.ie},
						st.w_data, st.w_strb));
				`EIS_OFF_EXTENDED_IRQ_ENABLE_REG_1:
					next_st.extended_irq_enable_reg_1 = 8'(wmerge({24'h0, st.extended_irq_enable_reg_1},
						st.w_data, st.w_strb));
				`EIS_OFF_EXTENDED_IRQ_ENABLE_REG_2:
					next_st.extended_irq_enable_reg_2 = 8'(wmerge({24'h0, st.extended_irq_enable_reg_2},
						st.w_data, st.w_strb));
				`EIS_OFF_PRIO1:
					next_st.prio1 = 17'(wmerge({15'h0, st.prio1},
						st.w_data, st.w_strb));
				`EIS_OFF_PRIO2:
					if (st.w_strb[0])
						next_st.prio2 = st.w_data[0];
				// writing one sets a flag like an event [R12]
				`EIS_OFF_PEND:
					next_st.pend = 17'(wmerge({15'h0, st.pend},
						st.w_data, st.w_strb));
				// software may turn the regulator off [R15]
				`EIS_OFF_REGCN:
					if (st.w_strb[0])
						next_st.reg_en = st.w_data[`EIS_REG_EN_BIT];
				`EIS_OFF_STAT: ;
				default: next_st.bresp = `EIS_RESP_SLVERR;
			endcase
		end
		if (st.bvalid && bready)
			next_st.bvalid = 1'b0;

		// read answered the cycle after the address is taken
		if (arvalid && arready)
		begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_word;
			next_st.rresp = rd_hit ? `EIS_RESP_OKAY : `EIS_RESP_SLVERR;
		end
		else if (st.rvalid && rready)
			next_st.rvalid = 1'b0;

		// vector taken: mark level in service, maybe clear flag
		if (irq_ack && st.req)
		begin
			next_st.active[st.req_lvl] = 1'b1; // [R3]
			if (st.req_src < `EIS_DROP_SRC && AUTO_CLR[st.req_src])
				next_st.pend[st.req_src] = 1'b0; // [R10]
		end

		// return closes the innermost routine [R4]
		if (return_from_interrupt_done)
		begin
			if (st.active[1])
				next_st.active[1] = 1'b0;
			else
				next_st.active[0] = 1'b0;
		end

		// events applied last so a set beats any clear [R2]
		next_st.pend = next_st.pend | src_event;

		// request is a flop: an enable cleared now leaves the latched
		// request up one more cycle, so a core finishing a one-cycle
		// instruction may still take it [R8]
		next_st.req = 1'b0;
		if (irq_ack && st.req)
			next_st.req = 1'b0;
		else if (hi_any && !st.active[1])
		begin
			// high preempts a low routine [R16]
			next_st.req = 1'b1;
			next_st.req_lvl = 1'b1;
			next_st.req_src = hi_idx;
		end
		else if (lo_any && st.active == 2'b00)
		begin
			// flag left set after a return lands here again [R11]
			next_st.req = 1'b1;
			next_st.req_lvl = 1'b0;
			next_st.req_src = lo_idx;
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register

	// synchronous reset; regulator comes up enabled
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= '0;
			st.ie <= `EIS_IE_RST;
			st.reg_en <= `EIS_REG_EN_RST; // [R15]
		end
		else
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	// ready held low while a response is outstanding
	assign awready = !st.aw_got && !st.bvalid;
	assign wready = !st.w_got && !st.bvalid;
	assign arready = !st.rvalid;
	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign rvalid = st.rvalid;
	assign rdata = st.rdata;
	assign rresp = st.rresp;
	assign irq_req = st.req;
	assign irq_vector = st.req_src;
	assign irq_level = st.req_lvl;
	assign regulator_enable = st.reg_en;

	////////////////////////////////////////////////////////////////////
	// checks

	// no request without the global enable the cycle before
	AST_GLOBAL_GATE: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
		irq_req |-> $past(st.ie[`EIS_GEN_BIT]))
		else $error("request raised with global enable low");

	// the requested source was eligible when latched
	AST_SRC_ENABLED: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
		irq_req |-> ((($past(elig)) >> irq_vector) & 18'h1) != 18'h0)
		else $error("request for a source that was not eligible");

	// every event leaves its flag set next cycle
	AST_EVENT_SETS: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
		(|src_event) |=> ((st.pend & $past(src_event))
			== $past(src_event)))
		else $error("event did not set its pending flag");

	// nothing is requested while a high routine runs
	AST_HIGH_BLOCKS: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
		(st.active[1] && !return_from_interrupt_done) |=> !irq_req)
		else $error("request raised during high-level routine");

	// flag still set after the return raises a new request
	AST_RETRIGGER: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
		(return_from_interrupt_done && st.active == 2'b01) ##1 (lo_any && !hi_any)
			|=> irq_req && !irq_level)
		else $error("no new request after return with flag set");

	// auto-clearing flag drops when its vector is taken
	AST_AUTO_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
		(irq_ack && irq_req && irq_vector < `EIS_DROP_SRC
			&& AUTO_CLR[irq_vector] && src_event == 17'h0)
			|=> !st.pend[$past(irq_vector)])
		else $error("auto-clearing flag stayed set after vector");

	// dropout requests only while its synced level was high
	AST_DROP_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
		(irq_req && irq_vector == `EIS_DROP_SRC) |-> $past(drop_sync))
		else $error("dropout request without dropout level");

	// regulator enabled right after reset
	AST_REG_RESET: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
		$past(!aresetn) |-> regulator_enable)
		else $error("regulator not enabled after reset");

	// return from nested high routine leaves the low one running
	AST_NEST_RETURN: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
		(return_from_interrupt_done && st.active == 2'b11 && !irq_ack) |=> st.active == 2'b01)
		else $error("nested return did not restore low routine");
endmodule
`default_nettype wire

/* File: dv/eis_core_model.sv */
// eis_core_model: behavioural core that takes and returns from requests
// assumes: one aclk domain; request outputs of the controller registered
`timescale 1ns/10ps
`default_nettype none
module eis_core_model
#(
	parameter int SVC = 30
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// request side
	input wire logic irq_req,
	input wire logic [4:0] irq_vector,
	input wire logic irq_level,
	input wire logic take,
	output logic irq_ack,
	output logic return_from_interrupt_done,
	// observation for the bench
	output logic [7:0] ack_count,
	output logic [4:0] last_vec,
	output logic last_lvl,
	output logic [1:0] depth
);
	int cnt; // cycles left in the innermost routine
	////////////////////////////////////////////////////////////////////
	// ack a standing request once, return after SVC cycles
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_ack <= 1'b0;
			return_from_interrupt_done <= 1'b0;
			ack_count <= 8'h00;
			last_vec <= 5'h00;
			last_lvl <= 1'b0;
			depth <= 2'h0;
			cnt <= 0;
		end
		else
		begin
			// one pulse per request, so a slow drop is not taken twice
			irq_ack <= take && irq_req && !irq_ack;
			return_from_interrupt_done <= 1'b0;
			if (irq_ack && irq_req)
			begin
				ack_count <= ack_count + 8'h01;
				last_vec <= irq_vector;
				last_lvl <= irq_level;
				depth <= depth + 2'h1;
				cnt <= SVC;
			end
			else if (depth != 2'h0 && cnt == 0)
			begin
				// every routine ends with a return
				return_from_interrupt_done <= 1'b1;
				depth <= depth - 2'h1;
				cnt <= SVC;
			end
			else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
endmodule
`default_nettype wire

/* File: dv/extended_interrupt_system_tb.sv */
// extended_interrupt_system_tb: self-checking bench of the controller
// assumes: eis_cfg.svh offsets; core model answers the request side
`timescale 1ns/10ps
`default_nettype none
`include "eis_cfg.svh"
module extended_interrupt_system_tb;
	// bus and pins
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, dropout_in, irq_req;
	logic irq_level, irq_ack, return_from_interrupt_done, regulator_enable, take, last_lvl;
	logic [7:0] awaddr, araddr, ack_count, n0;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs, depth;
	logic [2:0] awprot, arprot;
	logic [16:0] src_event, exp_p, tmp;
	logic [4:0] irq_vector, last_vec;
	int failures = 0;
	int check_count = 0;
	int cyc = 0;
	integer seed = 32'hf0e586d4;
	always #5 aclk = ~aclk;
	eis_irq_ctrl
	#(
		.ADDR_W(8),
		.AUTO_CLR(17'h00010)
	)
	i_dut
	(
		.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(awprot),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(arprot), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .src_event(src_event),
		.dropout_in(dropout_in), .irq_req(irq_req),
		.irq_vector(irq_vector), .irq_level(irq_level),
		.irq_ack(irq_ack), .return_from_interrupt_done(return_from_interrupt_done),
		.regulator_enable(regulator_enable)
	);
	eis_core_model i_core
	(
		.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req),
		.irq_vector(irq_vector), .irq_level(irq_level), .take(take),
		.irq_ack(irq_ack), .return_from_interrupt_done(return_from_interrupt_done),
		.ack_count(ack_count), .last_vec(last_vec),
		.last_lvl(last_lvl), .depth(depth)
	);
	////////////////////////////////////////////////////////////////////
	// case inequality, so an unknown never matches
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task print_verdict();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			print_verdict();
		end
	end
	// lowest flagged index wins among equals
	function automatic logic [4:0] lowest(input logic [16:0] p);
		lowest = 5'h1f;
		for (int i = 16; i >= 0; i--)
			if (p[i])
				lowest = 5'(i);
	endfunction
	task waitc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task wack(input logic [7:0] n);
		while (ack_count !== n) @(posedge aclk);
	endtask
	// write: both halves offered, each dropped when taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task rdreg(input logic [7:0] a);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////
	initial
	begin
		aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0;
		arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0;
		wstrb = 4'hf; awprot = 0; arprot = 0; src_event = 0;
		dropout_in = 0; take = 0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rdreg(`EIS_OFF_IE);
		chk(rd, 32'h0);
		chk(32'(rs), 32'(`EIS_RESP_OKAY));
		rdreg(`EIS_OFF_REGCN);
		chk(rd, 32'h80);
		chk(32'(regulator_enable), 32'h1);
		wr(8'h24, 32'h1);
		chk(32'(rs), 32'(`EIS_RESP_SLVERR));
		// unmapped read gives zero and an error answer
		rdreg(8'h24);
		chk(rd, 32'h0);
		chk(32'(rs), 32'(`EIS_RESP_SLVERR));
		// random events while every enable is low
		exp_p = '0;
		repeat (6)
		begin
			@(posedge aclk);
			tmp = 17'($random(seed)) | 17'h10000;
			src_event <= tmp;
			exp_p = exp_p | tmp;
		end
		@(posedge aclk);
		src_event <= '0;
		waitc(3);
		chk(32'(irq_req), 32'h0);
		rdreg(`EIS_OFF_PEND);
		chk(rd, 32'(exp_p));
		wr(`EIS_OFF_EXTENDED_IRQ_ENABLE_REG_1, 32'hff);
		chk(32'(rs), 32'(`EIS_RESP_OKAY));
		wr(`EIS_OFF_EXTENDED_IRQ_ENABLE_REG_2, 32'h06);
		wr(`EIS_OFF_IE, 32'h7f);
		waitc(3);
		chk(32'(irq_req), 32'h0);
		wr(`EIS_OFF_IE, 32'hff);
		waitc(3);
		chk(32'(irq_req), 32'h1);
		chk(32'(irq_vector), 32'(lowest(exp_p)));
		chk(32'(irq_level), 32'h0);
		// stale request stands one cycle after the clear, then drops
		wr(`EIS_OFF_IE, 32'h7f);
		chk(32'(irq_req), 32'h1);
		waitc(2);
		chk(32'(irq_req), 32'h0);
		wr(`EIS_OFF_PEND, 32'h0);
		wr(`EIS_OFF_IE, 32'hff);
		take <= 1'b1;
		n0 = ack_count;
		wr(`EIS_OFF_PEND, 32'h20);
		wack(n0 + 8'h01);
		chk(32'(last_vec), 32'h5);
		// flag left set, so the return re-enters
		wack(n0 + 8'h02);
		wr(`EIS_OFF_PEND, 32'h0);
		while (depth !== 2'h0) @(posedge aclk);
		waitc(5);
		chk(32'(ack_count), 32'(n0 + 8'h02));
		// hardware-cleared flag
		wr(`EIS_OFF_PEND, 32'h10);
		while (depth !== 2'h0 || ack_count === n0 + 8'h02) @(posedge aclk);
		waitc(5);
		rdreg(`EIS_OFF_PEND);
		chk(rd, 32'h0);
		chk(32'(ack_count), 32'(n0 + 8'h03));
		// high request preempts a low routine
		wr(`EIS_OFF_PRIO1, 32'h4);
		n0 = ack_count;
		wr(`EIS_OFF_PEND, 32'h2);
		wack(n0 + 8'h01);
		chk(32'(last_lvl), 32'h0);
		wr(`EIS_OFF_PEND, 32'h6);
		wack(n0 + 8'h02);
		chk(32'(last_vec), 32'h2);
		chk(32'(last_lvl), 32'h1);
		chk(32'(depth), 32'h2);
		// both levels in service, no request standing
		rdreg(`EIS_OFF_STAT);
		chk(32'(rd[11:9]), 32'h6);
		wr(`EIS_OFF_PEND, 32'h0);
		while (depth !== 2'h0) @(posedge aclk);
		// flagless dropout source
		take <= 1'b0;
		wr(`EIS_OFF_IE, 32'h80);
		wr(`EIS_OFF_EXTENDED_IRQ_ENABLE_REG_2, 32'h01);
		wr(`EIS_OFF_PRIO2, 32'h1);
		dropout_in <= 1'b1;
		waitc(6);
		chk(32'(irq_req), 32'h1);
		chk(32'(irq_vector), 32'(`EIS_DROP_SRC));
		chk(32'(irq_level), 32'h1);
		rdreg(`EIS_OFF_REGCN);
		chk(rd, 32'h81);
		dropout_in <= 1'b0;
		waitc(6);
		rdreg(`EIS_OFF_REGCN);
		chk(rd, 32'h80);
		chk(32'(irq_req), 32'h0);
		wr(`EIS_OFF_REGCN, 32'h0);
		waitc(2);
		chk(32'(regulator_enable), 32'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
